// ===== hdl/ras_pkg.sv
`default_nettype none
package ras_pkg;
	// Storage shape: entries 1..31 hold return addresses, pointer zero is the empty state.
	localparam int RAS_ADDR_W = 21;
	localparam int RAS_PTR_W = 5;
	localparam int RAS_DEPTH = 31;
	localparam logic [4:0] RAS_PTR_RST = 5'h00;
	localparam logic [4:0] RAS_PTR_EMPTY = 5'h00;
	localparam logic [4:0] RAS_PTR_MAX = 5'h1f;
	localparam logic [20:0] RAS_PC_ZERO = 21'h000000;

	// Pointer register layout and reset values.
	localparam int RAS_FULL_BIT = 7;
	localparam int RAS_UNF_BIT = 6;
	localparam int RAS_PTR_LSB = 0;
	localparam logic RAS_FLAG_RST = 1'b0;
	localparam logic [7:0] RAS_RDATA_RST = 8'h00;

	// Byte lanes of a stored entry as seen through the top-of-stack registers.
	localparam int RAS_UPPER_LSB = 16;
	localparam int RAS_UPPER_W = 5;
	localparam int RAS_HIGH_LSB = 8;
	localparam int RAS_LOW_LSB = 0;

	// Register selector of the special-function register port.
	typedef enum logic [1:0] {
		RAS_SEL_POINTER = 2'b00,
		RAS_SEL_TOP_UPPER = 2'b01,
		RAS_SEL_TOP_HIGH = 2'b10,
		RAS_SEL_TOP_LOW = 2'b11
	} ras_sel_t;

	// Stack operations requested by the instruction sequencer.
	typedef enum logic [2:0] {
		RAS_OP_PUSH_INSTR = 3'b000,
		RAS_OP_CALL = 3'b001,
		RAS_OP_RELATIVE_CALL = 3'b010,
		RAS_OP_IRQ_ACK = 3'b011,
		RAS_OP_RETURN = 3'b100,
		RAS_OP_RETURN_WITH_LITERAL = 3'b101,
		RAS_OP_RETURN_FROM_INTERRUPT = 3'b110,
		RAS_OP_POP_INSTR = 3'b111
	} ras_op_t;
endpackage : ras_pkg
`default_nettype wire

// ===== hdl/ras_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ras_mem_if #(
	parameter int ADDR_W = 21
);
	// One asynchronous read port at the pointer and one synchronous write port.
	logic [4:0] rd_addr;
	logic [ADDR_W-1:0] rd_data;
	logic wr_en;
	logic [4:0] wr_addr;
	logic [ADDR_W-1:0] wr_data;

	modport ctrl (output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
	modport store (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface : ras_mem_if
`default_nettype wire

// ===== hdl/ras_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ras_mem #(
	parameter int DEPTH = 31,
	parameter int ADDR_W = 21
) (
	// Clock
	input wire logic sys_clk,
	// Storage port
	ras_mem_if.store mem
);
	import ras_pkg::*;

	logic [ADDR_W-1:0] entry_ff [1:DEPTH];

	// Entries are written on the clock; index zero has no storage and reads as zero.
	always_ff @(posedge sys_clk) begin
		if (mem.wr_en && (mem.wr_addr != RAS_PTR_EMPTY)) begin
			entry_ff[mem.wr_addr] <= mem.wr_data; // R1
		end
	end

	// Read of the entry that the pointer selects.
	always_comb begin
		if (mem.rd_addr == RAS_PTR_EMPTY) begin
			mem.rd_data = '0;
		end else begin
			mem.rd_data = entry_ff[mem.rd_addr];
		end
	end
endmodule : ras_mem
`default_nettype wire

// ===== hdl/ras_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] Thirty-one entries of 21 bits, five-bit pointer.
// [R2] Every reset zeroes pointer; zero holds nothing.
// [R3] Push increments pointer, then stores PC.
// [R4] Return loads top into PC, then decrements.
// [R5] Push, calls and interrupt acknowledge push.
// [R6] Returns pop into PC, latches untouched.
// [R7] Top entry readable, writable as three bytes.
// [R8] Software reads and writes the pointer.
// [R9] Full flag after thirty-one pushes.
// [R10] Option off: hold at 31, ignore pushes.
// [R11] Option on: overflow sets full, resets, pointer zero.
// [R12] Pop at zero: PC zero, underflow set.
// [R13] Option on: underflow also resets device.
// [R14] Flags cleared only by software or power-on.
// [R15] Full bit 7, underflow 6, bit 5 zero.
// [R16] Pop instruction only decrements the pointer.
// [R17] Software masks interrupts during top access.
// [R18] Top registers read zero, ignore writes at zero.
module ras_top (
	// Clock and power-on reset
	input wire logic sys_clk,
	input wire logic rst,
	// Other resets and configuration
	input wire logic other_reset,
	input wire logic overflow_reset_enable,
	// Instruction sequencer
	input wire logic op_valid,
	input wire ras_pkg::ras_op_t op_kind,
	input wire logic [20:0] pc_in,
	output logic pc_load,
	output logic [20:0] pc_out,
	output logic stack_reset_req,
	// Special-function register port
	input wire ras_pkg::ras_sel_t reg_sel,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Status
	output logic [7:0] stack_pointer_status
);
	import ras_pkg::*;

	// Classifies a sequencer request as a push of the program counter.
	function automatic logic f_is_push(input ras_op_t k);
		return (k == RAS_OP_PUSH_INSTR) || (k == RAS_OP_CALL) ||
			(k == RAS_OP_RELATIVE_CALL) || (k == RAS_OP_IRQ_ACK);
	endfunction : f_is_push

	// Classifies a sequencer request as a return into the program counter.
	function automatic logic f_is_return(input ras_op_t k);
		return (k == RAS_OP_RETURN) || (k == RAS_OP_RETURN_WITH_LITERAL) ||
			(k == RAS_OP_RETURN_FROM_INTERRUPT);
	endfunction : f_is_return

	logic [4:0] ptr_ff;
	logic [4:0] nxt_ptr;
	logic full_ff;
	logic nxt_full;
	logic unf_ff;
	logic nxt_unf;
	logic [20:0] pc_out_ff;
	logic [20:0] nxt_pc_out;
	logic pc_load_ff;
	logic nxt_pc_load;
	logic rst_req_ff;
	logic nxt_rst_req;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic do_push;
	logic do_return;
	logic do_pop;
	logic at_empty;
	logic at_max;
	logic [20:0] merged_top;
	logic [7:0] ptr_view;

	ras_mem_if #(.ADDR_W(RAS_ADDR_W)) mem ();

	ras_mem #(
		.DEPTH(RAS_DEPTH),
		.ADDR_W(RAS_ADDR_W)
	) u_mem (
		.sys_clk(sys_clk),
		.mem(mem)
	);

	// Request decode and pointer conditions.
	assign do_push = op_valid && f_is_push(op_kind); // R5
	assign do_return = op_valid && f_is_return(op_kind); // R6
	assign do_pop = op_valid && (op_kind == RAS_OP_POP_INSTR);
	assign at_empty = (ptr_ff == RAS_PTR_EMPTY);
	assign at_max = (ptr_ff == RAS_PTR_MAX);
	assign mem.rd_addr = ptr_ff;
	assign ptr_view = {full_ff, unf_ff, 1'b0, ptr_ff}; // R15

	// Top entry with one byte lane replaced by a software write.
	always_comb begin
		merged_top = mem.rd_data;
		unique case (reg_sel)
			RAS_SEL_TOP_UPPER: merged_top[RAS_UPPER_LSB +: RAS_UPPER_W] = reg_wdata[4:0];
			RAS_SEL_TOP_HIGH: merged_top[RAS_HIGH_LSB +: 8] = reg_wdata;
			RAS_SEL_TOP_LOW: merged_top[RAS_LOW_LSB +: 8] = reg_wdata;
			RAS_SEL_POINTER: merged_top = mem.rd_data;
		endcase
	end

	// Next state: software access first, then stack operations, then the other resets.
	always_comb begin
		nxt_ptr = ptr_ff;
		nxt_full = full_ff;
		nxt_unf = unf_ff;
		nxt_pc_out = pc_out_ff;
		nxt_pc_load = 1'b0;
		nxt_rst_req = 1'b0;
		mem.wr_en = 1'b0;
		mem.wr_addr = ptr_ff;
		mem.wr_data = merged_top;
		if (reg_wr) begin
			if (reg_sel == RAS_SEL_POINTER) begin
				nxt_ptr = reg_wdata[RAS_PTR_LSB +: RAS_PTR_W]; // R8
				// Flag bits can only be cleared by writing zero to them.
				if (!reg_wdata[RAS_FULL_BIT]) begin
					nxt_full = 1'b0; // R14
				end
				if (!reg_wdata[RAS_UNF_BIT]) begin
					nxt_unf = 1'b0; // R14
				end
			end else if (!at_empty) begin
				mem.wr_en = 1'b1; // R7 R18
			end
		end
		if (do_push) begin
			if (at_max) begin
				nxt_full = 1'b1;
				if (overflow_reset_enable) begin
					nxt_ptr = RAS_PTR_RST; // R11
					nxt_rst_req = 1'b1; // R11
				end else begin
					nxt_ptr = RAS_PTR_MAX; // R10
				end
			end else begin
				nxt_ptr = ptr_ff + 5'h01; // R3
				mem.wr_en = 1'b1;
				mem.wr_addr = ptr_ff + 5'h01; // R3
				mem.wr_data = pc_in; // R3
				if (ptr_ff == RAS_PTR_MAX - 5'h01) begin
					nxt_full = 1'b1; // R9
				end
			end
		end else if (do_return) begin
			nxt_pc_load = 1'b1; // R6
			if (at_empty) begin
				nxt_pc_out = RAS_PC_ZERO; // R12
				nxt_unf = 1'b1; // R12
				nxt_ptr = RAS_PTR_EMPTY; // R12
				nxt_rst_req = overflow_reset_enable; // R13
			end else begin
				nxt_pc_out = mem.rd_data; // R4
				nxt_ptr = ptr_ff - 5'h01; // R4
			end
		end else if (do_pop) begin
			if (at_empty) begin
				nxt_unf = 1'b1;
				nxt_ptr = RAS_PTR_EMPTY;
				nxt_rst_req = overflow_reset_enable; // R13
			end else begin
				nxt_ptr = ptr_ff - 5'h01; // R16
			end
		end
		// Any other reset zeroes the pointer but leaves both flags alone.
		if (other_reset) begin
			nxt_ptr = RAS_PTR_RST; // R2 R14
		end
	end

	// Register read data, captured from the state before this cycle's update.
	always_comb begin
		nxt_rdata = rdata_ff;
		if (reg_rd) begin
			unique case (reg_sel)
				RAS_SEL_POINTER: nxt_rdata = ptr_view; // R8 R15
				RAS_SEL_TOP_UPPER: nxt_rdata = {3'b000, mem.rd_data[RAS_UPPER_LSB +: RAS_UPPER_W]}; // R7
				RAS_SEL_TOP_HIGH: nxt_rdata = mem.rd_data[RAS_HIGH_LSB +: 8]; // R7
				RAS_SEL_TOP_LOW: nxt_rdata = mem.rd_data[RAS_LOW_LSB +: 8]; // R7
			endcase
		end
	end

	// State registers; power-on reset clears pointer and flags.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ptr_ff <= RAS_PTR_RST; // R2
			full_ff <= RAS_FLAG_RST; // R14
			unf_ff <= RAS_FLAG_RST; // R14
			pc_out_ff <= RAS_PC_ZERO;
			pc_load_ff <= 1'b0;
			rst_req_ff <= 1'b0;
			rdata_ff <= RAS_RDATA_RST;
		end else begin
			ptr_ff <= nxt_ptr;
			full_ff <= nxt_full;
			unf_ff <= nxt_unf;
			pc_out_ff <= nxt_pc_out;
			pc_load_ff <= nxt_pc_load;
			rst_req_ff <= nxt_rst_req;
			rdata_ff <= nxt_rdata;
		end
	end

	// Outputs come straight from flip-flops.
	assign pc_load = pc_load_ff;
	assign pc_out = pc_out_ff;
	assign stack_reset_req = rst_req_ff;
	assign reg_rdata = rdata_ff;
	assign stack_pointer_status = ptr_view;

	// A normal push stores the program counter where the new pointer points.
	property p_push_store;
		@(posedge sys_clk) disable iff (rst)
		(do_push && !at_max && !other_reset) |=>
			(ptr_ff == $past(ptr_ff) + 5'h01) && (mem.rd_data == $past(pc_in));
	endproperty
	a_push_store: assert property (p_push_store) else $error("push did not store pc"); // R3

	// A return reads the top entry into the pc and then steps down.
	property p_return_load;
		@(posedge sys_clk) disable iff (rst)
		(do_return && !at_empty && !other_reset) |=>
			pc_load && (pc_out == $past(mem.rd_data)) && (ptr_ff == $past(ptr_ff) - 5'h01);
	endproperty
	a_return_load: assert property (p_return_load) else $error("return load wrong"); // R4

	// The call, relative call and interrupt acknowledge requests move the pointer up from empty.
	property p_push_kinds;
		@(posedge sys_clk) disable iff (rst)
		(op_valid && (op_kind inside {RAS_OP_CALL, RAS_OP_RELATIVE_CALL, RAS_OP_IRQ_ACK})
			&& at_empty && !other_reset) |=> (ptr_ff == 5'h01) && !pc_load;
	endproperty
	a_push_kinds: assert property (p_push_kinds) else $error("push kind not pushed"); // R5

	// The pop instruction only discards the top entry.
	property p_pop_instr;
		@(posedge sys_clk) disable iff (rst)
		(do_pop && !at_empty && !other_reset) |=>
			(ptr_ff == $past(ptr_ff) - 5'h01) && !pc_load && !stack_reset_req;
	endproperty
	a_pop_instr: assert property (p_pop_instr) else $error("pop instruction wrong"); // R16

	// The thirty-first push sets the full flag.
	property p_full_set;
		@(posedge sys_clk) disable iff (rst)
		(do_push && (ptr_ff == 5'h1e) && !other_reset) |=> full_ff && (ptr_ff == 5'h1f);
	endproperty
	a_full_set: assert property (p_full_set) else $error("full flag not set"); // R9

	// Overflow with the option off holds the pointer at its top.
	property p_overflow_hold;
		@(posedge sys_clk) disable iff (rst)
		(do_push && at_max && !overflow_reset_enable && !other_reset) |=>
			(ptr_ff == 5'h1f) && full_ff && !stack_reset_req;
	endproperty
	a_overflow_hold: assert property (p_overflow_hold) else $error("overflow not held"); // R10

	// Overflow with the option on resets the stack and keeps the flag.
	property p_overflow_reset;
		@(posedge sys_clk) disable iff (rst)
		(do_push && at_max && overflow_reset_enable) |=>
			(ptr_ff == 5'h00) && full_ff && stack_reset_req ##1 !stack_reset_req;
	endproperty
	a_overflow_reset: assert property (p_overflow_reset) else $error("overflow reset wrong"); // R11

	// A return from an empty stack loads zero and flags underflow.
	property p_underflow;
		@(posedge sys_clk) disable iff (rst)
		(do_return && at_empty) |=> pc_load && (pc_out == 21'h000000) && unf_ff && at_empty;
	endproperty
	a_underflow: assert property (p_underflow) else $error("underflow wrong"); // R12

	// Underflow requests a reset exactly when the option is on.
	property p_underflow_reset;
		@(posedge sys_clk) disable iff (rst)
		((do_return || do_pop) && at_empty) |=> (stack_reset_req == $past(overflow_reset_enable));
	endproperty
	a_underflow_reset: assert property (p_underflow_reset) else $error("underflow reset wrong"); // R13

	// Other resets zero the pointer and keep both flags.
	property p_other_reset;
		@(posedge sys_clk) disable iff (rst)
		(other_reset && !op_valid && !reg_wr) |=>
			at_empty && (full_ff == $past(full_ff)) && (unf_ff == $past(unf_ff));
	endproperty
	a_other_reset: assert property (p_other_reset) else $error("other reset touched flags"); // R14

	// Pointer register read shows the flags and a zero bit 5.
	property p_ptr_read;
		@(posedge sys_clk) disable iff (rst)
		(reg_rd && (reg_sel == RAS_SEL_POINTER)) |=>
			(reg_rdata == {$past(full_ff), $past(unf_ff), 1'b0, $past(ptr_ff)});
	endproperty
	a_ptr_read: assert property (p_ptr_read) else $error("pointer read wrong"); // R15

	// Top-of-stack reads at the empty position return zero.
	property p_empty_top_read;
		@(posedge sys_clk) disable iff (rst)
		(reg_rd && (reg_sel != RAS_SEL_POINTER) && at_empty) |=> (reg_rdata == 8'h00);
	endproperty
	a_empty_top_read: assert property (p_empty_top_read) else $error("empty top not zero"); // R18
endmodule : ras_top
`default_nettype wire

// ===== sim/ras_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module ras_seq_model (
	// Clock
	input wire logic sys_clk,
	// Requests to the stack
	output logic op_valid,
	output ras_pkg::ras_op_t op_kind,
	output logic [20:0] pc_in
);
	import ras_pkg::*;
	// Quiet request lines at time zero.
	initial begin
		op_valid = 1'b0;
		op_kind = RAS_OP_RETURN;
		pc_in = 21'h000000;
	end
	// One request for one taken edge; idle operands are scrambled so no stale value helps.
	// Requests are only issued when the bench asks, never during register access.
	task automatic do_op(input ras_op_t k, input logic [20:0] pc);
		@(negedge sys_clk);
		op_valid = 1'b1;
		op_kind = k;
		pc_in = pc;
		@(negedge sys_clk);
		op_valid = 1'b0;
		op_kind = ras_op_t'(~k);
		pc_in = ~pc;
	endtask : do_op
endmodule : ras_seq_model
`default_nettype wire

// ===== sim/tb_return_address_stack.sv
`timescale 1ns/1ps
`default_nettype none
module tb_return_address_stack;
	import ras_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic other_reset = 1'b0;
	logic overflow_reset_enable = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	ras_sel_t reg_sel = RAS_SEL_POINTER;
	logic [7:0] reg_wdata = 8'h00;
	logic op_valid, pc_load, stack_reset_req;
	ras_op_t op_kind;
	logic [20:0] pc_in, pc_out;
	logic [7:0] reg_rdata, status;
	int err_count = 0;
	int checked = 0;

	// Clock at 20 MHz.
	always #25 sys_clk = ~sys_clk;

	ras_top uut (
		.sys_clk(sys_clk), .rst(rst), .other_reset(other_reset),
		.overflow_reset_enable(overflow_reset_enable), .op_valid(op_valid),
		.op_kind(op_kind), .pc_in(pc_in), .pc_load(pc_load), .pc_out(pc_out),
		.stack_reset_req(stack_reset_req), .reg_sel(reg_sel), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.stack_pointer_status(status)
	);

	ras_seq_model seq (.sys_clk(sys_clk), .op_valid(op_valid), .op_kind(op_kind), .pc_in(pc_in));

	// Byte and program-counter comparisons.
	task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_b

	task automatic chk_pc(input logic [20:0] got, input logic [20:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_pc

	// One register access held over one taken edge; read data is settled on return.
	task automatic reg_op(input ras_sel_t s, input logic w, input logic [7:0] d);
		@(negedge sys_clk);
		reg_sel = s;
		reg_wr = w;
		reg_rd = ~w;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	endtask : reg_op

	// Two pushes, byte reads of the top, a top rewrite and two returns.
	task automatic t_push_pop();
		seq.do_op(RAS_OP_CALL, 21'h1abcde);
		seq.do_op(RAS_OP_RELATIVE_CALL, 21'h012345);
		chk_b(status, 8'h02);
		reg_op(RAS_SEL_TOP_UPPER, 1'b0, 8'h00);
		chk_b(reg_rdata, 8'h01);
		reg_op(RAS_SEL_TOP_HIGH, 1'b0, 8'h00);
		chk_b(reg_rdata, 8'h23);
		reg_op(RAS_SEL_TOP_LOW, 1'b1, 8'h99);
		seq.do_op(RAS_OP_RETURN, 21'h000000);
		chk_b({7'h00, pc_load}, 8'h01);
		chk_pc(pc_out, 21'h012399);
		chk_b(status, 8'h01);
		seq.do_op(RAS_OP_RETURN_WITH_LITERAL, 21'h000000);
		chk_pc(pc_out, 21'h1abcde);
		$display("push_pop done");
	endtask : t_push_pop

	// Return from an empty stack with the reset option off and on, then clear by software.
	task automatic t_underflow();
		for (int e = 0; e < 2; e++) begin
			overflow_reset_enable = e[0];
			seq.do_op(RAS_OP_RETURN_FROM_INTERRUPT, 21'h000000);
			chk_pc(pc_out, 21'h000000);
			chk_b(status, 8'h40);
			chk_b({7'h00, stack_reset_req}, {7'h00, e[0]});
			reg_op(RAS_SEL_POINTER, 1'b1, 8'h00);
			chk_b(status, 8'h00);
		end
		reg_op(RAS_SEL_TOP_HIGH, 1'b1, 8'h55);
		reg_op(RAS_SEL_TOP_HIGH, 1'b0, 8'h00);
		chk_b(reg_rdata, 8'h00);
		reg_op(RAS_SEL_POINTER, 1'b1, 8'h01);
		reg_op(RAS_SEL_TOP_HIGH, 1'b0, 8'h00);
		chk_b(reg_rdata, 8'hbc);
		reg_op(RAS_SEL_POINTER, 1'b1, 8'h00);
		$display("underflow done");
	endtask : t_underflow

	// Fill to 31, refused push, discard, other reset, pointer write and overflow reset.
	task automatic t_full();
		overflow_reset_enable = 1'b0;
		for (int i = 0; i < 31; i++) begin
			seq.do_op(ras_op_t'(i[1:0]), 21'(i));
		end
		chk_b(status, 8'h9f);
		seq.do_op(RAS_OP_IRQ_ACK, 21'h0000aa);
		chk_b(status, 8'h9f);
		reg_op(RAS_SEL_TOP_LOW, 1'b0, 8'h00);
		chk_b(reg_rdata, 8'h1e);
		seq.do_op(RAS_OP_POP_INSTR, 21'h000000);
		chk_b({pc_load, status[6:0]}, 8'h1e);
		reg_op(RAS_SEL_TOP_LOW, 1'b0, 8'h00);
		chk_b(reg_rdata, 8'h1d);
		@(negedge sys_clk);
		other_reset = 1'b1;
		@(negedge sys_clk);
		other_reset = 1'b0;
		chk_b(status, 8'h80);
		reg_op(RAS_SEL_POINTER, 1'b1, 8'hff);
		chk_b(status, 8'h9f);
		overflow_reset_enable = 1'b1;
		seq.do_op(RAS_OP_PUSH_INSTR, 21'h000001);
		chk_b({stack_reset_req, 7'h00}, 8'h80);
		chk_b(status, 8'h80);
		$display("full done");
	endtask : t_full

	// Underflow on a discard, software clear of full alone, pointer read, then power-on reset.
	task automatic t_flags();
		seq.do_op(RAS_OP_POP_INSTR, 21'h000000);
		chk_b(status, 8'hc0);
		chk_b({7'h00, stack_reset_req}, 8'h01);
		reg_op(RAS_SEL_POINTER, 1'b1, 8'h40);
		chk_b(status, 8'h40);
		reg_op(RAS_SEL_POINTER, 1'b0, 8'h00);
		chk_b(reg_rdata, 8'h40);
		@(negedge sys_clk);
		rst = 1'b1;
		@(negedge sys_clk);
		rst = 1'b0;
		chk_b(status, 8'h00);
		chk_b(reg_rdata, 8'h00);
		$display("flags done");
	endtask : t_flags

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	// Main sequence after a six-cycle power-on reset.
	initial begin
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		chk_b(status, 8'h00);
		t_push_pop();
		t_underflow();
		t_full();
		t_flags();
		results();
	end

	// Cuts a hang short well beyond the roughly 120 cycles the tests need.
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_count++;
		results();
	end
endmodule : tb_return_address_stack
`default_nettype wire
